// [hdl/char_fifo.v]
// small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module char_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    reg full_r;
    wire push;
    wire pop;
    // sized at counter width so the compare below is exact
    localparam [AW:0] LAST_CNT = DEPTH - 1;
    // registered full flag keeps in_ready off the counter compare path
    assign in_ready = !full_r;
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge mclk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
            full_r <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_r <= count_r + {{AW{1'b0}}, 1'b1};
                full_r <= (count_r == LAST_CNT);
            end else if (pop && !push) begin
                count_r <= count_r - {{AW{1'b0}}, 1'b1};
                full_r <= 1'b0;
            end
        end
    end
endmodule

// [hdl/flow_consts.vh]
// constants for the in-band pause/resume flow control block
`ifndef FLOW_CONSTS_VH
`define FLOW_CONSTS_VH
`define CH_RESUME 8'h11
`define CH_PAUSE 8'h13
`define CH_ENQ 8'h05
`define CH_ACK 8'h06
`define DATA_W 8
`define FIFO_DEPTH 8
`define FIFO_AW 3
`endif

// [hdl/flow_ctrl.v]
// in-band pause/resume flow control between a local source and a serial peer
// Notes on behaviour
// RQ1: resume code is 0x11, used to restart a paused transmitter.
// RQ2: pause code is 0x13, used to halt the transmitter.
// RQ3: on pause, stop handing further data characters to the link.
// RQ4: stay halted until resume arrives, then continue sending.
// RQ5: resume from the exact queued character, nothing skipped or repeated.
// RQ6: resume while not paused is ignored.
// RQ7: the remote receiver sends pause when behind and resume once caught up.
// RQ8: control codes must lie outside payload; escaping covers the overlap.
// RQ9: optional mode: a doubled control code is one literal data character.
// RQ10: optional alternate pacing: enquiry 0x05 pauses, acknowledge 0x06 resumes.
// RQ11: flow characters are consumed and never delivered as receive payload.
// RQ12: a character already handed to the shifter completes before halting.
`timescale 1ns/1ps
`include "flow_consts.vh"
module flow_ctrl (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // mode straps, sampled through two flops
    input wire escape_en,
    input wire enq_ack_mode,
    // local transmit source
    input wire src_valid,
    output wire src_ready,
    input wire [`DATA_W-1:0] src_data,
    // character transmitter (one character per handshake)
    output reg tx_valid,
    input wire tx_ready,
    output reg [`DATA_W-1:0] tx_data,
    // character receiver
    input wire rx_valid,
    input wire [`DATA_W-1:0] rx_data,
    // receive payload out
    output reg rxo_valid,
    output reg [`DATA_W-1:0] rxo_data,
    // status
    output reg paused
);
    localparam ST_NORMAL = 2'b01;
    localparam ST_HELD = 2'b10;

    reg [1:0] esc_sync_r;
    reg [1:0] mode_sync_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg pend_r;
    reg [`DATA_W-1:0] pend_data_r;
    wire q_valid;
    wire q_ready;
    wire [`DATA_W-1:0] q_data;
    wire esc_on;
    wire alt_on;
    wire [`DATA_W-1:0] code_pause;
    wire [`DATA_W-1:0] code_resume;
    wire is_pause;
    wire is_resume;
    wire is_ctrl;
    wire literal;

    char_fifo #(
        .WIDTH(`DATA_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(src_valid),
        .in_ready(src_ready),
        .in_data(src_data),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_data)
    );

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            esc_sync_r <= 2'b00;
            mode_sync_r <= 2'b00;
        end else begin
            esc_sync_r <= {esc_sync_r[0], escape_en};
            mode_sync_r <= {mode_sync_r[0], enq_ack_mode};
        end
    end
    assign esc_on = esc_sync_r[1];
    assign alt_on = mode_sync_r[1];

    assign code_pause = alt_on ? `CH_ENQ : `CH_PAUSE; // RQ2 RQ10
    assign code_resume = alt_on ? `CH_ACK : `CH_RESUME; // RQ1 RQ10
    assign is_pause = rx_data == code_pause;
    assign is_resume = rx_data == code_resume;
    assign is_ctrl = is_pause || is_resume; // RQ8
    // second identical control code in a row is a literal
    assign literal = esc_on && pend_r && rx_data == pend_data_r; // RQ9

    always @* begin
        state_nxt = state_r;
        // with escaping, a code acts only once the next character proves it single
        if (!esc_on && rx_valid && is_ctrl) begin
            case (state_r)
                ST_NORMAL: begin
                    if (is_pause) begin
                        state_nxt = ST_HELD; // RQ3
                    end
                end
                ST_HELD: begin
                    if (is_resume) begin
                        state_nxt = ST_NORMAL; // RQ4 RQ6
                    end
                end
                default: begin
                    state_nxt = ST_NORMAL;
                end
            endcase
        end else if (esc_on && rx_valid && pend_r && !literal) begin
            // held single code is now confirmed as control
            case (state_r)
                ST_NORMAL: begin
                    if (pend_data_r == code_pause) begin
                        state_nxt = ST_HELD; // RQ3
                    end
                end
                ST_HELD: begin
                    if (pend_data_r == code_resume) begin
                        state_nxt = ST_NORMAL; // RQ4 RQ6
                    end
                end
                default: begin
                    state_nxt = ST_NORMAL;
                end
            endcase
        end
    end

    // fifo pops only when the tx register is empty or the link takes its character, so position is kept
    assign q_ready = (state_r == ST_NORMAL) && (!tx_valid || tx_ready); // RQ5

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_NORMAL;
            pend_r <= 1'b0;
            pend_data_r <= {`DATA_W{1'b0}};
            tx_valid <= 1'b0;
            tx_data <= {`DATA_W{1'b0}};
            rxo_valid <= 1'b0;
            rxo_data <= {`DATA_W{1'b0}};
            paused <= 1'b0;
        end else begin
            state_r <= state_nxt;
            paused <= state_nxt == ST_HELD;
            rxo_valid <= 1'b0;
            // the pending code is resolved on the next received character
            if (rx_valid) begin
                if (literal) begin
                    pend_r <= 1'b0;
                    rxo_valid <= 1'b1; // RQ9
                    rxo_data <= rx_data;
                end else if (esc_on && is_ctrl) begin
                    pend_r <= 1'b1; // RQ11
                    pend_data_r <= rx_data;
                end else if (!is_ctrl) begin
                    pend_r <= 1'b0;
                    rxo_valid <= 1'b1;
                    rxo_data <= rx_data;
                end
            end else if (!esc_on) begin
                pend_r <= 1'b0;
            end
            // an accepted character stays offered until taken, even if paused
            if (q_valid && q_ready) begin
                tx_valid <= 1'b1;
                tx_data <= q_data;
            end else if (tx_ready) begin
                tx_valid <= 1'b0; // RQ12
            end
        end
    end
endmodule

// [verification/flow_ctrl_sva.sv]
// assertions on the flow control ports
`timescale 1ns/1ps
module flow_ctrl_sva (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // straps and source
    input wire escape_en,
    input wire enq_ack_mode,
    input wire src_ready,
    // transmitter, receiver, status
    input wire tx_valid,
    input wire tx_ready,
    input wire [7:0] tx_data,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rxo_valid,
    input wire [7:0] rxo_data,
    input wire paused
);
    logic [1:0] settle_r;
    // straps pass two sync flops, so trust them only after three edges
    wire ok = settle_r == 2'h3 && !escape_en;
    wire plain = ok && !enq_ack_mode;
    wire rx_13 = rx_valid && rx_data == 8'h13;
    wire rx_11 = rx_valid && rx_data == 8'h11;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) settle_r <= 2'h0;
        else if (settle_r != 2'h3) settle_r <= settle_r + 2'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_pause_halts: assert property (
        plain && rx_13 |=> paused) else $error("pause code ignored");
    a_resume_runs: assert property (
        plain && paused && rx_11 |=> !paused) else $error("resume code ignored");
    a_stray_resume: assert property (
        plain && !paused && rx_11 |=> !paused) else $error("stray resume paused");
    a_alt_codes: assert property (
        ok && enq_ack_mode && rx_valid && (rx_data == 8'h05 || rx_data == 8'h06)
        |=> paused == ($past(rx_data) == 8'h05)) else $error("alternate codes ignored");
    a_no_new_send: assert property (
        paused && !tx_valid |=> !tx_valid)
        else $error("sent while paused");
    a_offer_holds: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("offer dropped");
    a_codes_eaten: assert property (
        plain && (rx_13 || rx_11) |=> !rxo_valid) else $error("flow code delivered");
    a_payload_out: assert property (
        plain && rx_valid && rx_data > 8'h13 |=> rxo_valid && rxo_data == $past(rx_data))
        else $error("payload lost");
    c_pause: cover property (paused && tx_valid && tx_ready);
    c_full: cover property (!src_ready);
    c_escape: cover property (escape_en && rxo_valid && rxo_data == 8'h13);
    c_alt: cover property (enq_ack_mode && paused);
endmodule
bind flow_ctrl flow_ctrl_sva chk_i (.mclk(mclk), .rst_b(rst_b), .escape_en(escape_en),
    .enq_ack_mode(enq_ack_mode), .src_ready(src_ready), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
    .rxo_valid(rxo_valid), .rxo_data(rxo_data), .paused(paused));

// [verification/serial_peer.sv]
// remote serial peer: takes characters, stalls on command
`timescale 1ns/1ps
module serial_peer (
    // clock and control
    input wire mclk,
    input wire stall,
    // transmitter side
    input wire tx_valid,
    input wire [7:0] tx_data,
    output wire tx_ready
);
    logic [7:0] got[$];
    assign tx_ready = !stall;
    always @(posedge mclk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
    end
endmodule

// [verification/tb.sv]
// self-checking bench for the flow control block
`timescale 1ns/1ps
module tb;
    logic mclk = 0, rst_b = 0, escape_en = 0, enq_ack_mode = 0, stall = 1;
    logic src_valid = 0, rx_valid = 0;
    logic [7:0] src_data = 8'h00, rx_data = 8'h00;
    wire src_ready, tx_valid, tx_ready, rxo_valid, paused;
    wire [7:0] tx_data, rxo_data;
    int n_errors = 0, n_compared = 0, i, k = 0;
    // received char, payload expected, paused expected
    logic [9:0] rows [0:5] = '{{8'h41, 2'b10}, {8'h11, 2'b00}, {8'h13, 2'b01},
        {8'h13, 2'b01}, {8'h11, 2'b00}, {8'h7E, 2'b10}};
    flow_ctrl uut (.mclk(mclk), .rst_b(rst_b), .escape_en(escape_en),
        .enq_ack_mode(enq_ack_mode), .src_valid(src_valid), .src_ready(src_ready),
        .src_data(src_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .rx_valid(rx_valid), .rx_data(rx_data), .rxo_valid(rxo_valid),
        .rxo_data(rxo_data), .paused(paused));
    serial_peer peer (.mclk(mclk), .stall(stall), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task test_done;
        if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task rst(input logic e, input logic q);
        rst_b = 0;
        escape_en = e;
        enq_ack_mode = q;
        repeat (8) @(negedge mclk);
        rst_b = 1;
        repeat (4) @(negedge mclk);
    endtask
    // one received character, outputs settled on return
    task rx(input logic [7:0] d);
        @(negedge mclk);
        rx_valid = 1;
        rx_data = d;
        @(negedge mclk);
        rx_valid = 0;
    endtask
    initial forever #5 mclk = ~mclk;
    initial begin
        rst(0, 0);
        chk(src_ready, 1);
        chk(paused, 0);
        chk(tx_valid, 0);
        chk(rxo_valid, 0);
        for (i = 0; i < 6; i++) begin
            rx(rows[i][9:2]);
            chk(rxo_valid, rows[i][1]);
            if (rows[i][1]) chk(rxo_data, rows[i][9:2]);
            chk(paused, rows[i][0]);
        end
        // peer stalled: fill until the buffer refuses
        repeat (14) begin
            @(negedge mclk);
            src_valid = src_ready;
            src_data = 8'hA0 + k;
            if (src_ready) k++;
        end
        chk(src_ready, 0);
        chk(k, 9);
        rx(8'h13);
        stall = 0;
        repeat (20) @(negedge mclk);
        chk(peer.got.size(), 1);
        rx(8'h11);
        for (i = 0; i < 60 && peer.got.size() < k; i++) @(negedge mclk);
        chk(peer.got.size(), k);
        for (i = 0; i < k; i++) chk(peer.got[i], 8'hA0 + i);
        rst(1, 0);
        rx(8'h13);
        chk(rxo_valid, 0);
        rx(8'h13);
        chk(rxo_valid, 1);
        chk(rxo_data, 8'h13);
        chk(paused, 0);
        rx(8'h13);
        rx(8'h41);
        chk(rxo_data, 8'h41);
        chk(paused, 1);
        rx(8'h20);
        chk(paused, 1);
        rx(8'h11);
        chk(paused, 1);
        rx(8'h13);
        chk(paused, 0);
        rx(8'h41);
        chk(paused, 1);
        rst(0, 1);
        rx(8'h05);
        chk(paused, 1);
        rx(8'h06);
        chk(paused, 0);
        rx(8'h13);
        chk(rxo_valid, 1);
        chk(paused, 0);
        test_done;
    end
endmodule
